// File: hdl/rog_pkg.sv
// Package: constants and types of the 8 kHz reference, one-second and pin select block
package rog_pkg;
  localparam int NPORT = 12;
  localparam int NPIN = 24;
  // Register byte offsets
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_PSRC = 6'h04;
  localparam logic [5:0] A_TXSEL = 6'h08;
  localparam logic [5:0] A_PINLO = 6'h0C;
  localparam logic [5:0] A_PINHI = 6'h10;
  localparam logic [5:0] A_PININ = 6'h14;
  localparam logic [5:0] A_STAT = 6'h18;
  localparam logic [5:0] A_MASK = 6'h1C;
  localparam logic [5:0] A_STATE = 6'h20;
  // Writable bits of each register
  localparam logic [31:0] M_CTRL = 32'h00000FF3;
  localparam logic [31:0] M_PSRC = 32'h00FFFFFF;
  localparam logic [31:0] M_TXSEL = 32'h00000FFF;
  localparam logic [31:0] M_PINLO = 32'hFFFFFFFF;
  localparam logic [31:0] M_PINHI = 32'h0000FFFF;
  localparam logic [31:0] M_MASK = 32'h00000001;
  localparam logic [1:0] R_OK = 2'h0;
  localparam logic [1:0] R_ERR = 2'h2;
  // Divisors to 8 kHz and to one second
  localparam logic [12:0] DIV_DS3 = 13'h15D8;
  localparam logic [12:0] DIV_E3 = 13'h10C8;
  localparam logic [12:0] DIV_CC = 13'h1950;
  localparam logic [12:0] DIV_SEC = 13'h1F40;
  // Source and mode codes
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_DS3 = 4'h1;
  localparam logic [3:0] SRC_E3 = 4'h2;
  localparam logic [3:0] SRC_CC = 4'h3;
  localparam logic [3:0] SRC_PORT = 4'h4;
  localparam logic [1:0] LM_DS3 = 2'h0;
  localparam logic [1:0] LM_E3 = 2'h1;
  localparam logic [1:0] PM_IN = 2'h0;
  localparam logic [1:0] PM_ALARM = 2'h1;
  localparam logic [1:0] PM_LOW = 2'h2;
  localparam logic [1:0] GPM_PIN = 2'h1;
  // Pins with global functions, counted from zero
  localparam int PIN_ROUT = 1;
  localparam int PIN_RIN = 3;
  localparam int PIN_ERR = 5;
  localparam int PIN_PMU = 7;
  // Control register layout
  typedef struct packed {
    logic [19:0] rsvdHi;
    logic adapterEn;
    logic [1:0] gpmSel;
    logic errInsSel;
    logic [3:0] srcSel;
    logic [1:0] rsvdLo;
    logic outEn;
    logic extInSel;
  } rog_ctrl_t;
  // Whole state of the block
  typedef struct packed {
    logic [31:0] ctrl, psrc, txSel, pinLo, pinHi, mask;
    logic stat;
    logic [12:0] gCnt, sCnt;
    logic [NPORT-1:0][12:0] pCnt;
    logic refLvl, refTick, secLvl, pm_update, errIns;
    logic [NPIN-1:0] pinS1, pinS2, pinS3, gOut, gOe;
    logic [2:0] ckS1, ckS2, ckS3;
    logic [NPORT-1:0] rxS1, rxS2, rxS3, txS1, txS2, txS3, plcpTick;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } rog_state_t;
endpackage

// File: hdl/rog_ref_select.sv
// Top: global and port 8 kHz references, one-second tick, pin select, AXI4-Lite registers
// Summary of operation
// - External select takes global reference from pin 4, ignoring source field.
// - Output enable drives global reference out on pin 2.
// - Source field: 0 off, 1-3 DS3/E3/52 clock, 4-15 port 1-12.
// - Port source: 0X receive PLCP, 10 receive line clock, 11 transmit clock.
// - Per port bit picks global or port reference for transmit PLCP.
// - Divisors 6480 for 51.84 MHz, 5592 for DS3, 4296 for E3.
// - Port divisor follows line mode; global divisor follows chosen clock.
// - One-second signal is global reference divided by 8000, about half duty.
// - Rising one-second edge sets latched flag; interrupt when enabled.
// - Update field 1X makes each one-second edge a monitor update.
// - 24 pins, each input, output, global signal or alarm output.
// - Pins of absent ports still work as plain or global pins.
// - Reference, error insert and update inputs read low when pin unselected.
// - Pin 6 is error insert input, pin 8 the update input.
// - Pin mode 00 input, 01 alarm, 10 low, 11 high.
// - After reset reference generator and one-second timer are off.
// - All pins are inputs after reset.
// - Source off without external select powers down reference and one-second logic.
`timescale 1ns/1ps
module rog_ref_select (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite write
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock sources: adapter ticks on clk, clock pins asynchronous
  input wire logic [2:0] adapterTick,
  input wire logic [2:0] adapterClockPin,
  input wire logic [11:0] rxLineClock,
  input wire logic [11:0] txClockIn,
  input wire logic [11:0] rxPlcpTick,
  input wire logic [23:0] portLineMode,
  // Pins
  input wire logic [23:0] gpioIn,
  output logic [23:0] gpioOut,
  output logic [23:0] gpioOe,
  input wire logic [23:0] portAlarm,
  // Core outputs
  output logic eightKhzRef,
  output logic globalRefTick,
  output logic [11:0] txPlcpTick,
  output logic oneSecond,
  output logic pmUpdate,
  output logic manualErrorInsert,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // State and decoded fields
  rog_pkg::rog_state_t st, next_st;
  rog_pkg::rog_ctrl_t ctrl;
  logic [47:0] pinModes;
  logic [11:0] pTick, pLvl, pWrap;
  logic [11:0][12:0] pNext;
  logic [23:0] nOut, nOe;
  logic [3:0] pIdx;
  logic gEn, gEdge, gTick, extIn, extRise, secRise, wrDo, rdDo;
  logic [12:0] gDiv;

  assign ctrl = rog_pkg::rog_ctrl_t'(st.ctrl);
  assign pinModes = {st.pinHi[15:0], st.pinLo};
  assign pIdx = ctrl.srcSel - rog_pkg::SRC_PORT;

  // Line-mode to divisor
  function automatic logic [12:0] divFor(input logic [1:0] mode);
    divFor = (mode == rog_pkg::LM_DS3) ? rog_pkg::DIV_DS3 :
      (mode == rog_pkg::LM_E3) ? rog_pkg::DIV_E3 : rog_pkg::DIV_CC;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
    input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    merge = r & msk;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Per-port dividers and pin muxing
  genvar i;
  generate
    for (i = 0; i < 24; i++) begin : g_ch
      if (i < 12) begin : g_port
        logic [1:0] sel;
        logic [12:0] div;
        logic edgeIn;
        assign sel = st.psrc[2*i +: 2];
        assign div = divFor(portLineMode[2*i +: 2]);
        // Edge of rx line clock or tx clock pin
        assign edgeIn = sel[1] & (sel[0] ? (st.txS2[i] & ~st.txS3[i])
          : (st.rxS2[i] & ~st.rxS3[i]));
        assign pWrap[i] = edgeIn & (st.pCnt[i] == div - 13'h0001);
        assign pNext[i] = pWrap[i] ? 13'h0000 : st.pCnt[i] + {12'h000, edgeIn};
        // Divided output, or the receive PLCP reference
        assign pTick[i] = sel[1] ? pWrap[i] : rxPlcpTick[i];
        assign pLvl[i] = sel[1] ? (st.pCnt[i] < (div >> 1)) : rxPlcpTick[i];
      end
      // Pins of absent ports keep all their modes; nothing here depends on port count
      always_comb begin
        nOut[i] = 1'b0;
        nOe[i] = 1'b0;
        if (i == rog_pkg::PIN_ROUT && ctrl.outEn) begin
          nOut[i] = st.refLvl;
          nOe[i] = 1'b1;
        end else if ((i == rog_pkg::PIN_RIN && ctrl.extInSel) ||
            (i == rog_pkg::PIN_ERR && ctrl.errInsSel) ||
            (i == rog_pkg::PIN_PMU && ctrl.gpmSel == rog_pkg::GPM_PIN)) begin
          nOe[i] = 1'b0;
        end else if (pinModes[2*i +: 2] != rog_pkg::PM_IN) begin
          nOe[i] = 1'b1;
          nOut[i] = (pinModes[2*i +: 2] == rog_pkg::PM_ALARM) ? portAlarm[i]
            : (pinModes[2*i +: 2] != rog_pkg::PM_LOW);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Global source selection
  always_comb begin
    unique case (ctrl.srcSel)
      rog_pkg::SRC_DS3: gDiv = rog_pkg::DIV_DS3;
      rog_pkg::SRC_E3: gDiv = rog_pkg::DIV_E3;
      default: gDiv = rog_pkg::DIV_CC;
    endcase
  end
  // Pin clocks are sampled; they must stay below half of clk to be counted
  assign gEdge = (ctrl.srcSel >= rog_pkg::SRC_DS3) && (ctrl.srcSel < rog_pkg::SRC_PORT)
    && (ctrl.adapterEn ? adapterTick[ctrl.srcSel[1:0] - 2'h1]
    : (st.ckS2[ctrl.srcSel[1:0] - 2'h1] & ~st.ckS3[ctrl.srcSel[1:0] - 2'h1]));
  assign extIn = ctrl.extInSel & st.pinS2[rog_pkg::PIN_RIN];
  assign extRise = extIn & ~st.pinS3[rog_pkg::PIN_RIN];
  assign gEn = ctrl.extInSel | (ctrl.srcSel != rog_pkg::SRC_OFF);
  always_comb begin
    if (ctrl.extInSel) begin
      gTick = extRise;
    end else if (ctrl.srcSel >= rog_pkg::SRC_PORT) begin
      gTick = pTick[pIdx];
    end else begin
      // A count left from a longer divisor wraps at once instead of running to 8191
      gTick = gEdge & (st.gCnt >= gDiv - 13'h0001);
    end
  end
  assign secRise = gTick & (st.sCnt == rog_pkg::DIV_SEC - 13'h0001);
  assign wrDo = s_axi_awvalid & s_axi_wvalid & ~st.bvalid;
  assign rdDo = s_axi_arvalid & ~st.rvalid;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Two-flop synchronisers for pins; stage three only feeds edge detection
    next_st.pinS1 = gpioIn;
    next_st.pinS2 = st.pinS1;
    next_st.pinS3 = st.pinS2;
    next_st.ckS1 = adapterClockPin;
    next_st.ckS2 = st.ckS1;
    next_st.ckS3 = st.ckS2;
    next_st.rxS1 = rxLineClock;
    next_st.rxS2 = st.rxS1;
    next_st.rxS3 = st.rxS2;
    next_st.txS1 = txClockIn;
    next_st.txS2 = st.txS1;
    next_st.txS3 = st.txS2;
    for (int p = 0; p < 12; p++) begin
      next_st.pCnt[p] = pNext[p];
    end
    // Global divider counts only with an adapter clock source
    if (gEdge) begin
      next_st.gCnt = gTick ? 13'h0000 : st.gCnt + 13'h0001;
    end
    if (ctrl.extInSel) begin
      next_st.refLvl = extIn;
    end else if (!gEn) begin
      next_st.refLvl = 1'b0;
    end else if (ctrl.srcSel >= rog_pkg::SRC_PORT) begin
      next_st.refLvl = pLvl[pIdx];
    end else begin
      next_st.refLvl = st.gCnt < (gDiv >> 1);
    end
    next_st.refTick = gTick;
    // One-second divider holds while the source is off
    if (gTick) begin
      next_st.sCnt = secRise ? 13'h0000 : st.sCnt + 13'h0001;
    end
    next_st.secLvl = gEn & (next_st.sCnt < (rog_pkg::DIV_SEC >> 1));
    next_st.pm_update = (ctrl.gpmSel[1] & secRise) |
      ((ctrl.gpmSel == rog_pkg::GPM_PIN) & st.pinS2[rog_pkg::PIN_PMU]);
    next_st.errIns = ctrl.errInsSel & st.pinS2[rog_pkg::PIN_ERR];
    for (int p = 0; p < 12; p++) begin
      next_st.plcpTick[p] = st.txSel[p] ? pTick[p] : gTick;
    end
    next_st.gOut = nOut;
    next_st.gOe = nOe;
    // Write channel: address and data taken together
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wrDo) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = rog_pkg::R_OK;
      unique case ({s_axi_awaddr[5:2], 2'b00})
        rog_pkg::A_CTRL:
          next_st.ctrl = merge(st.ctrl, s_axi_wdata, s_axi_wstrb, rog_pkg::M_CTRL);
        rog_pkg::A_PSRC:
          next_st.psrc = merge(st.psrc, s_axi_wdata, s_axi_wstrb, rog_pkg::M_PSRC);
        rog_pkg::A_TXSEL:
          next_st.txSel = merge(st.txSel, s_axi_wdata, s_axi_wstrb, rog_pkg::M_TXSEL);
        rog_pkg::A_PINLO:
          next_st.pinLo = merge(st.pinLo, s_axi_wdata, s_axi_wstrb, rog_pkg::M_PINLO);
        rog_pkg::A_PINHI:
          next_st.pinHi = merge(st.pinHi, s_axi_wdata, s_axi_wstrb, rog_pkg::M_PINHI);
        rog_pkg::A_MASK:
          next_st.mask = merge(st.mask, s_axi_wdata, s_axi_wstrb, rog_pkg::M_MASK);
        rog_pkg::A_PININ, rog_pkg::A_STAT, rog_pkg::A_STATE: ;
        default: next_st.bresp = rog_pkg::R_ERR;
      endcase
    end
    // Read channel; reading status clears it
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rdDo) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = rog_pkg::R_OK;
      next_st.rdata = 32'h00000000;
      unique case ({s_axi_araddr[5:2], 2'b00})
        rog_pkg::A_CTRL: next_st.rdata = st.ctrl;
        rog_pkg::A_PSRC: next_st.rdata = st.psrc;
        rog_pkg::A_TXSEL: next_st.rdata = st.txSel;
        rog_pkg::A_PINLO: next_st.rdata = st.pinLo;
        rog_pkg::A_PINHI: next_st.rdata = st.pinHi;
        rog_pkg::A_PININ: next_st.rdata = {8'h00, st.pinS2};
        rog_pkg::A_STAT: begin
          next_st.rdata = {31'h00000000, st.stat};
          next_st.stat = 1'b0;
        end
        rog_pkg::A_MASK: next_st.rdata = st.mask;
        rog_pkg::A_STATE: next_st.rdata = {29'h00000000, gEn, st.secLvl, st.refLvl};
        default: next_st.rresp = rog_pkg::R_ERR;
      endcase
    end
    // A one-second edge in the clearing cycle still sets the flag
    if (secRise) begin
      next_st.stat = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset leaves sources off and pins as inputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = wrDo;
  assign s_axi_wready = wrDo;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign gpioOut = st.gOut;
  assign gpioOe = st.gOe;
  assign eightKhzRef = st.refLvl;
  assign globalRefTick = st.refTick;
  assign txPlcpTick = st.plcpTick;
  assign oneSecond = st.secLvl;
  assign pmUpdate = st.pm_update;
  assign manualErrorInsert = st.errIns;
  assign irq = st.stat & st.mask[0];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_ext_ref;
    (ctrl.extInSel && st.pinS2[rog_pkg::PIN_RIN] && !st.pinS3[rog_pkg::PIN_RIN])
      |=> globalRefTick;
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("pin 4 edge gave no tick");

  property p_ref_out;
    ctrl.outEn |=> gpioOe[rog_pkg::PIN_ROUT] && gpioOut[rog_pkg::PIN_ROUT] == $past(st.refLvl);
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("pin 2 not carrying ref");

  property p_ds3_wrap;
    (!ctrl.extInSel && ctrl.srcSel == rog_pkg::SRC_DS3 && gEdge
      && st.gCnt == rog_pkg::DIV_DS3 - 13'h0001) |-> gTick ##1 st.gCnt == 13'h0000;
  endproperty
  a_ds3_wrap: assert property (p_ds3_wrap) else $error("DS3 divider wrap wrong");

  property p_sec_rise;
    secRise |-> gTick && st.sCnt == 13'h1F3F ##1 st.sCnt == 13'h0000;
  endproperty
  a_sec_rise: assert property (p_sec_rise) else $error("one-second wrap wrong");

  property p_flag;
    secRise |=> st.stat;
  endproperty
  a_flag: assert property (p_flag) else $error("one-second flag not set");

  property p_update;
    (ctrl.gpmSel[1] && secRise) |=> pmUpdate;
  endproperty
  a_update: assert property (p_update) else $error("no monitor update");

  property p_err_low;
    !ctrl.errInsSel |=> !manualErrorInsert;
  endproperty
  a_err_low: assert property (p_err_low) else $error("error insert not forced low");

  property p_pin_high;
    (pinModes[1:0] == 2'h3) |=> gpioOe[0] && gpioOut[0];
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("pin 1 not driven high");

  property p_hold;
    // Pin 8 may still drive updates while off; only the one-second source must stay quiet
    (!gEn && ctrl.gpmSel != rog_pkg::GPM_PIN) ##1 (!gEn)
      |-> $stable(st.sCnt) && !secRise && !pmUpdate;
  endproperty
  a_hold: assert property (p_hold) else $error("one-second ran while off");

  property p_plcp_sel;
    (!st.txSel[0] && gTick) |=> txPlcpTick[0];
  endproperty
  a_plcp_sel: assert property (p_plcp_sel) else $error("global ref not on PLCP 1");

endmodule

// File: verif/tb_rog_ref_select.sv
// Testbench: registers, pin modes, reference dividers and one-second tick of the select block
`timescale 1ns/1ps
module tb_rog_ref_select;
  // Clock, reset and bus signals
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // Sources, pins and core outputs
  logic [2:0] adapterTick = 3'h0, adapterClockPin = 3'h0;
  logic [11:0] rxLineClock = 12'h000, txClockIn = 12'h000, rxPlcpTick = 12'h000;
  logic [23:0] portLineMode = 24'h000000, gpioIn = 24'h000000, portAlarm = 24'h000000;
  logic [23:0] gpioOut, gpioOe;
  logic [11:0] txPlcpTick;
  logic eightKhzRef, globalRefTick, oneSecond, pmUpdate, manualErrorInsert, irq;
  int errCount = 0;
  int samplesChecked = 0;
  int tickCnt = 0, pmCnt = 0, txCnt = 0, hiCnt = 0;
  logic [31:0] rd;
  logic [1:0] rr;

  rog_ref_select dut_u (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adapterTick(adapterTick), .adapterClockPin(adapterClockPin), .rxLineClock(rxLineClock),
    .txClockIn(txClockIn), .rxPlcpTick(rxPlcpTick), .portLineMode(portLineMode),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .portAlarm(portAlarm),
    .eightKhzRef(eightKhzRef), .globalRefTick(globalRefTick), .txPlcpTick(txPlcpTick),
    .oneSecond(oneSecond), .pmUpdate(pmUpdate), .manualErrorInsert(manualErrorInsert),
    .irq(irq)
  );

  always #5 clk = ~clk;

  // Pulse counters; the main sequence clears them on falling edges only
  always @(posedge clk) begin
    if (globalRefTick === 1'b1) tickCnt <= tickCnt + 1;
    if (globalRefTick === 1'b1 && oneSecond === 1'b1) hiCnt <= hiCnt + 1;
    if (pmUpdate === 1'b1) pmCnt <= pmCnt + 1;
    if (txPlcpTick[0] === 1'b1) txCnt <= txCnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
    tickCnt = 0;
    pmCnt = 0;
    txCnt = 0;
    hiCnt = 0;
  endtask

  // Bus master: ready sampled on the falling edge, release only after the taking edge
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge clk);
    while (s_axi_awready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(negedge clk);
    while (s_axi_bvalid !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    @(posedge clk);
    s_axi_bready <= 1'b0;
    if (n >= 100) errCount++;
  endtask

  task automatic axi_rd(input logic [5:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge clk);
    while (s_axi_arready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(negedge clk);
    while (s_axi_rvalid !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    if (n >= 100) errCount++;
  endtask

  // Tick-to-tick spacing of the global reference, in clock cycles
  task automatic period(input logic [31:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    while (globalRefTick !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
    @(negedge clk);
    n = 1;
    while (globalRefTick !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
    chk("refPeriod", exp, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the full run takes about 65k cycles
  initial begin
    #900000;
    errCount++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
    chk("gpioOe", 32'h0, gpioOe);
    chk("refOuts", 32'h0, {eightKhzRef, oneSecond, globalRefTick});
    axi_rd(rog_pkg::A_STATE);
    chk("stateReg", 32'h0, rd);
    axi_rd(6'h24);
    chk("unmappedResp", rog_pkg::R_ERR, rr);
    // Pin modes: high, low, alarm on the low bank and high on a pin of an absent port
    portAlarm <= 24'h000010;
    axi_wr(rog_pkg::A_PINLO, 32'h00000123);
    axi_wr(rog_pkg::A_PINHI, 32'h00000003);
    settle(3);
    chk("pinOe", 32'h00010015, gpioOe);
    chk("pinOut", 32'h00010011, gpioOut & gpioOe);
    @(posedge clk);
    portAlarm <= 24'h000000;
    settle(3);
    chk("alarmOut", 32'h00010001, gpioOut & gpioOe);
    @(posedge clk);
    gpioIn <= 24'hA500A8;
    settle(4);
    chk("unselGlobals", 32'h0, {manualErrorInsert, pmUpdate, 6'h00, tickCnt[23:0]});
    axi_rd(rog_pkg::A_PININ);
    chk("pinIn", 32'h00A500A8, rd);
    // Error insert from pin 6 and update level from pin 8
    axi_wr(rog_pkg::A_CTRL, 32'h00000300);
    settle(4);
    chk("pinGlobals", 32'h3, {manualErrorInsert, pmUpdate});
    @(posedge clk);
    gpioIn <= 24'h000000;
    // Port references: global from port 2, transmit framer of port 1 picks global or own
    axi_wr(rog_pkg::A_CTRL, 32'h00000050);
    for (int s = 0; s < 2; s++) begin
      axi_wr(rog_pkg::A_TXSEL, 32'(s));
      settle(2);
      @(posedge clk);
      rxPlcpTick <= 12'h002;
      @(posedge clk);
      rxPlcpTick <= 12'h000;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("portTick", 32'h1, tickCnt);
      chk("txTick", 32'(1 - s), txCnt);
    end
    // Divisors of the three adapter clocks
    @(posedge clk);
    adapterTick <= 3'h7;
    axi_wr(rog_pkg::A_CTRL, 32'h00000810);
    period(32'(rog_pkg::DIV_DS3));
    axi_wr(rog_pkg::A_CTRL, 32'h00000820);
    period(32'(rog_pkg::DIV_E3));
    axi_wr(rog_pkg::A_CTRL, 32'h00000830);
    period(32'(rog_pkg::DIV_CC));
    // Source off: no ticks even with the adapter still running
    axi_wr(rog_pkg::A_CTRL, 32'h00000800);
    settle(4);
    repeat (300) @(posedge clk);
    @(negedge clk);
    chk("offTicks", 32'h0, tickCnt);
    axi_rd(rog_pkg::A_STATE);
    chk("offState", 32'h0, rd);
    // External reference on pin 4, out on pin 2, one-second update and interrupt
    adapterTick <= 3'h0;
    axi_wr(rog_pkg::A_MASK, 32'h00000001);
    axi_wr(rog_pkg::A_CTRL, 32'h00000403);
    settle(2);
    @(posedge clk);
    for (int i = 0; i < 8000; i++) begin
      gpioIn <= 24'h000008;
      repeat (2) @(posedge clk);
      gpioIn <= 24'h000000;
      repeat (2) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("extTicks", 32'd8000, tickCnt);
    chk("pmPulses", 32'h1, pmCnt);
    chk("dutyHigh", 32'h1, 32'(hiCnt > 3998 && hiCnt < 4002));
    chk("refPin", {31'h0, eightKhzRef}, {31'h0, gpioOut[1]});
    chk("refPinOe", 32'h1, {31'h0, gpioOe[1]});
    chk("irqSet", 32'h1, {31'h0, irq});
    axi_rd(rog_pkg::A_STAT);
    chk("statSet", 32'h1, rd);
    settle(1);
    chk("irqClear", 32'h0, {31'h0, irq});
    axi_rd(rog_pkg::A_STAT);
    chk("statClear", 32'h0, rd);
    close_out();
  end
endmodule
